// ==== e1_frame_events_and_tx_framing_config_test.sv ====
`timescale 1ns/1ps

// ==========================================================
// bench for one channel, placed at channel 2
module e1_frame_events_and_tx_framing_config_test;
  localparam logic [2:0] CH = 3'h2;
  logic       i_ref_clk = 1'b0;
  logic       i_resetn  = 1'b0;
  logic       cs = 1'b0, rd = 1'b0, wr = 1'b0, nfas = 1'b0;
  logic       a_bit = 1'b0, e_zero = 1'b0, febe = 1'b0, ais = 1'b0;
  logic [9:0] addr  = 10'h000;
  logic [7:0] wdata = 8'h00, ev = 8'h00;
  logic [4:0] sa    = 5'h00;
  logic [7:0] rdata, tx_data, lb, lbyte;
  logic       int_n, tx_valid, tx_ready, take, lvalid, lmf, v, mf, ok;
  // code 00 sets the extra bit disable; CRC only with both disables low
  logic [7:0] cfg [5] = '{8'h60, 8'h62, 8'h68, 8'h01, 8'h70};
  logic [7:0] exp [5] = '{8'h9b, 8'h1b, 8'h55, 8'h9b, 8'h1b};
  int         n_fail = 0, checks = 0;

  always #12.5 i_ref_clk = ~i_ref_clk;

  efr_framer #(.CHANNEL(CH), .P_RAI_CYCLES(20), .P_SEC_CYCLES(1000))
  efr_framer_inst (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_cs(cs), .i_rd(rd),
    .i_wr(wr), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
    .o_int_n(int_n), .i_rx_frame_start(ev[3]), .i_rx_submf_start(ev[2]),
    .i_rx_mf_start(ev[1]), .i_rx_sigmf_start(ev[0]),
    .i_rx_nfas_strobe(nfas), .i_rx_sa_bits(sa), .i_offset_status(ev[7]),
    .i_link_id_status(ev[4]), .i_rx_a_bit(a_bit),
    .i_rx_e_bit_zero(e_zero), .i_rx_febe_pulse(febe),
    .i_rx_crc_fail(2'h0), .i_tx_data_in(tx_data), .i_tx_valid(tx_valid),
    .o_tx_ready(tx_ready), .i_tx_signalling_stream(8'h00),
    .i_tx_ais(ais), .i_line_take(take), .o_line_byte(lb),
    .o_line_valid(lvalid), .o_line_mf_start(lmf));

  efr_line_model efr_line_model_inst (
    .i_ref_clk(i_ref_clk), .i_tx_ready(tx_ready), .i_line_byte(lb),
    .i_line_valid(lvalid), .i_line_mf_start(lmf), .o_tx_data(tx_data),
    .o_tx_valid(tx_valid), .o_line_take(take));

  // ==========================================================
  // access tasks
  task automatic check(input logic [7:0] got, input logic [7:0] want);
    checks++;
    if (got !== want) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h want %h", $time, got, want);
    end
  endtask : check

  task automatic reg_wr(input logic [6:0] off, input logic [7:0] d);
    @(negedge i_ref_clk);
    {cs, wr, addr, wdata} = {2'b11, CH, off, d};
    @(negedge i_ref_clk);
    {cs, wr} = 2'b00;
  endtask : reg_wr

  task automatic reg_rd(input logic [9:0] a, input logic [7:0] want);
    @(negedge i_ref_clk);
    {cs, rd, addr} = {2'b11, a};
    @(negedge i_ref_clk);
    {cs, rd} = 2'b00;
    check(rdata, want);
  endtask : reg_rd

  // pulse inputs return low, status levels stay flipped
  task automatic kick(input int b);
    @(negedge i_ref_clk);
    ev[b] = ~ev[b];
    @(negedge i_ref_clk);
    if (b < 4) ev[b] = 1'b0;
    @(negedge i_ref_clk);
  endtask : kick

  // one sub-multiframe codeword, first bit lands in bit 3
  task automatic codeword(input logic [3:0] w);
    kick(2);
    for (int i = 3; i >= 0; i--) begin
      @(negedge i_ref_clk);
      {sa, nfas} = {w[i], {4{~w[i]}}, 1'b1};
      @(negedge i_ref_clk);
      nfas = 1'b0;
    end
  endtask : codeword

  task automatic end_of_test;
    if (n_fail == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  initial begin
    #1000000;
    n_fail++;
    end_of_test();
  end

  // ==========================================================
  // scenarios
  initial begin
    repeat (6) @(negedge i_ref_clk);
    i_resetn = 1'b1;
    reg_rd({CH, 7'h40}, 8'h60);
    reg_rd({CH, 7'h3e}, 8'h00);
    reg_wr(7'h3e, 8'h08);
    reg_rd({CH, 7'h3e}, 8'h08);
    reg_rd({CH, 7'h00}, 8'h00);
    // a foreign channel must not answer: the last read data stands
    reg_rd({3'h1, 7'h3e}, 8'h00);
    for (int p = 0; p < 2; p++)
      for (int b = 0; b < 8; b++) begin
        if (b == 5 || b == 6) continue;
        kick(b);
        check({7'h00, int_n}, {7'h00, b != 3});
        reg_rd({CH, 7'h3f}, 8'h01 << b);
        reg_rd({CH, 7'h3f}, 8'h00);
        check({7'h00, int_n}, 8'h01);
      end
    // too short a remote alarm, then a held one
    {a_bit, e_zero} = 2'b11;
    repeat (10) @(negedge i_ref_clk);
    a_bit = 1'b0;
    reg_rd({CH, 7'h3f}, 8'h00);
    a_bit = 1'b1;
    repeat (30) @(negedge i_ref_clk);
    reg_rd({CH, 7'h3f}, 8'h40);
    reg_rd({CH, 7'h3f}, 8'h00);
    {a_bit, e_zero} = 2'b00;
    // zero E bits every cycle across five full one-second windows
    febe = 1'b1;
    repeat (6100) @(negedge i_ref_clk);
    febe = 1'b0;
    reg_rd({CH, 7'h3f}, 8'h20);
    // national nibble on the Sa4 bit
    reg_wr(7'h3b, 8'h80);
    repeat (3) codeword(4'ha);
    kick(2);
    reg_rd({CH, 7'h3d}, 8'h0a);
    reg_rd({CH, 7'h3c}, 8'h10);
    codeword(4'h5);
    kick(2);
    reg_rd({CH, 7'h3d}, 8'h0a);
    codeword(4'h5);
    kick(2);
    reg_rd({CH, 7'h3d}, 8'h05);
    reg_rd({CH, 7'h3f}, 8'h04);
    // transmit: empty fifo refuses, reinit holds it
    efr_line_model_inst.pull(lbyte, v, mf);
    check({7'h00, v}, 8'h00);
    reg_wr(7'h40, 8'he0);
    efr_line_model_inst.push(8'h55, ok);
    efr_line_model_inst.pull(lbyte, v, mf);
    check({7'h00, v}, 8'h00);
    for (int k = 0; k < 5; k++) begin
      reg_wr(7'h40, cfg[k] | 8'h80);
      reg_wr(7'h40, cfg[k]);
      efr_line_model_inst.push(8'h55, ok);
      efr_line_model_inst.pull(lbyte, v, mf);
      check({7'h00, ok}, 8'h01);
      check(lbyte, exp[k]);
      check({6'h00, v, mf}, 8'h03);
    end
    // TS16 of frame 0 in CAS mode, then under the all-ones alarm
    for (int p = 0; p < 2; p++) begin
      ais = (p != 0);
      reg_wr(7'h40, 8'he0);
      reg_wr(7'h40, 8'h60);
      for (int t = 0; t < 17; t++) begin
        efr_line_model_inst.push(8'h55, ok);
        efr_line_model_inst.pull(lbyte, v, mf);
      end
      check(lbyte, (p != 0) ? 8'h55 : 8'h0b);
    end
    end_of_test();
  end
endmodule : e1_frame_events_and_tx_framing_config_test

// ==== efr_framer.sv ====
`timescale 1ns/1ps

// ============================================================
// transmit fifo
module efr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_clear,
  // fill side
  input  wire logic [WIDTH-1:0] i_in_data,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  // drain side
  output logic [WIDTH-1:0]      o_out_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [CW-1:0]               cnt;
    logic                        ready;
  } efr_fifo_state_t;

  efr_fifo_state_t q;
  efr_fifo_state_t n;
  logic            push;
  logic            pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : bump

  assign o_in_ready  = q.ready;
  assign o_out_valid = (q.cnt != '0);
  assign o_out_data  = q.mem[q.rp];

  always_comb begin
    n    = q;
    push = i_in_valid && q.ready;
    pop  = i_out_ready && (q.cnt != '0);
    if (i_clear) begin
      n.wp  = '0;
      n.rp  = '0;
      n.cnt = '0;
    end else begin
      if (push) begin
        n.mem[q.wp] = i_in_data;
        n.wp        = bump(q.wp);
      end
      if (pop) begin
        n.rp = bump(q.rp);
      end
      n.cnt = q.cnt + CW'(push) - CW'(pop);
    end
    // ready is a flop so the backplane never sees a comb path
    n.ready = (n.cnt != CW'(DEPTH));
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

endmodule : efr_fifo

// ============================================================
// one framer channel
module efr_framer #(
  parameter logic [2:0] CHANNEL      = 3'h0,
  parameter int         P_RAI_CYCLES = efr_pkg::RAI_CYCLES,
  parameter int         P_SEC_CYCLES = efr_pkg::SEC_CYCLES,
  parameter int         FIFO_DEPTH   = 4
) (
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_resetn,
  // processor port
  input  wire logic       i_cs,
  input  wire logic       i_rd,
  input  wire logic       i_wr,
  input  wire logic [9:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  output logic            o_int_n,
  // receive processor
  input  wire logic       i_rx_frame_start,
  input  wire logic       i_rx_submf_start,
  input  wire logic       i_rx_mf_start,
  input  wire logic       i_rx_sigmf_start,
  input  wire logic       i_rx_nfas_strobe,
  input  wire logic [4:0] i_rx_sa_bits,
  input  wire logic       i_offset_status,
  input  wire logic       i_link_id_status,
  input  wire logic       i_rx_a_bit,
  input  wire logic       i_rx_e_bit_zero,
  input  wire logic       i_rx_febe_pulse,
  input  wire logic [1:0] i_rx_crc_fail,
  // backplane transmit
  input  wire logic [7:0] i_tx_data_in,
  input  wire logic       i_tx_valid,
  output logic            o_tx_ready,
  input  wire logic [7:0] i_tx_signalling_stream,
  input  wire logic       i_tx_ais,
  // line side
  input  wire logic       i_line_take,
  output logic      [7:0] o_line_byte,
  output logic            o_line_valid,
  output logic            o_line_mf_start
);

  efr_pkg::efr_state_t q;
  efr_pkg::efr_state_t n;
  efr_pkg::efr_rx_ev_t set_ev;
  logic [4:0]          sa_set;
  logic                hit;
  logic                wr;
  logic                rd;
  logic                rd_ev;
  logic [6:0]          off;
  logic [7:0]          fifo_data;
  logic                fifo_valid;
  logic                produce;
  logic [7:0]          b;
  logic [7:0]          cb;
  logic [3:0]          acc;
  logic                ebit;

  // ==========================================================
  // helpers
  function automatic logic [4:0] sa_onehot(input logic [2:0] sel);
    if (sel == efr_pkg::SEL_SA4) begin
      sa_onehot = 5'h10;
    end else if (sel == efr_pkg::SEL_SA5) begin
      sa_onehot = 5'h08;
    end else if (sel == efr_pkg::SEL_SA6) begin
      sa_onehot = 5'h04;
    end else if (sel == efr_pkg::SEL_SA7) begin
      sa_onehot = 5'h02;
    end else if (sel == efr_pkg::SEL_SA8) begin
      sa_onehot = 5'h01;
    end else begin
      sa_onehot = 5'h00; // RULE22
    end
  endfunction : sa_onehot

  function automatic logic [3:0] crc4_byte(input logic [3:0] c,
                                           input logic [7:0] d);
    logic [3:0] r;
    logic       fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[3] ^ d[i];
      r  = {r[2:0], 1'b0} ^ (fb ? efr_pkg::CRC4_POLY : 4'h0);
    end
    crc4_byte = r;
  endfunction : crc4_byte

  // ==========================================================
  // transmit fifo
  efr_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_resetn    (i_resetn),
    .i_clear     (q.cfg.gen_fifo_reinit), // RULE11
    .i_in_data   (i_tx_data_in),
    .i_in_valid  (i_tx_valid),
    .o_in_ready  (o_tx_ready),
    .o_out_data  (fifo_data),
    .o_out_valid (fifo_valid),
    .i_out_ready (produce)
  );

  assign o_rdata         = q.rdata;
  assign o_int_n         = q.int_n;
  assign o_line_byte     = q.line_byte;
  assign o_line_valid    = q.line_valid;
  assign o_line_mf_start = q.line_mf_start;

  // ==========================================================
  // next state
  always_comb begin
    n       = q;
    off     = i_addr[6:0];
    hit     = i_cs && (i_addr[9:efr_pkg::CH_LSB] == CHANNEL); // RULE1
    wr      = hit && i_wr;
    rd      = hit && i_rd;
    rd_ev   = rd && (off == efr_pkg::OFF_EV_FLAGS);
    sa_set  = '0;
    produce = !q.cfg.gen_fifo_reinit && i_line_take && fifo_valid;
    b       = fifo_data; // RULE14 RULE20
    cb      = 8'h00;
    acc     = q.crc_acc;
    ebit    = 1'b1;

    // receive events
    set_ev                      = '0;
    set_ev.offset_change        = i_offset_status != q.oof_q;   // RULE6
    set_ev.link_id_change       = i_link_id_status != q.link_q; // RULE7
    set_ev.frame_pulse          = i_rx_frame_start;             // RULE10
    set_ev.crc_submf_pulse      = i_rx_submf_start;             // RULE10
    set_ev.crc_mf_pulse         = i_rx_mf_start;                // RULE10
    set_ev.sig_mf_pulse         = i_rx_sigmf_start;             // RULE10
    n.oof_q                     = i_offset_status;
    n.link_q                    = i_link_id_status;

    // remote alarm with far-end error, held for the full window
    if (i_rx_a_bit && i_rx_e_bit_zero) begin
      if (q.ra_cnt < 32'(P_RAI_CYCLES - 1)) begin
        n.ra_cnt = q.ra_cnt + 32'h1;
      end else begin
        n.ra_on             = 1'b1;
        set_ev.remote_alarm = !q.ra_on; // RULE8
      end
    end else begin
      n.ra_cnt = '0;
      n.ra_on  = 1'b0;
    end

    // one-second windows of zero E-bit counts
    if (q.sec_cnt >= 32'(P_SEC_CYCLES - 1)) begin
      n.sec_cnt  = '0;
      n.febe_cnt = {10'h000, i_rx_febe_pulse};
      if (q.febe_cnt > efr_pkg::FEBE_LIMIT) begin
        if (q.run == efr_pkg::FEBE_SECONDS - 3'h1) begin
          set_ev.continuous_far_error = 1'b1; // RULE9
        end
        if (q.run != efr_pkg::FEBE_SECONDS) begin
          n.run = q.run + 3'h1;
        end
      end else begin
        n.run = '0;
      end
    end else begin
      n.sec_cnt = q.sec_cnt + 32'h1;
      if (i_rx_febe_pulse && (q.febe_cnt != 11'h7ff)) begin
        n.febe_cnt = q.febe_cnt + 11'h1;
      end
    end

    // national-bit nibble, first bit ends in bit 3
    if (i_rx_nfas_strobe) begin
      n.collect = {q.collect[2:0],
                   |(sa_onehot(q.sa_sel) & i_rx_sa_bits)}; // RULE2
    end
    if (i_rx_submf_start) begin
      n.cand = q.collect;
      if ((q.collect == q.cand) && (q.collect != q.nibble)) begin
        n.nibble = q.collect;            // RULE3
        sa_set   = sa_onehot(q.sa_sel);  // RULE23
      end
    end

    // register writes
    if (wr) begin
      if (off == efr_pkg::OFF_EV_EN) begin
        n.ev_en = i_wdata;
      end else if (off == efr_pkg::OFF_TX_CFG) begin
        n.cfg = i_wdata; // RULE11
      end else if (off == efr_pkg::OFF_SA_CTRL) begin
        n.sa_sel = i_wdata[7:5];
        n.sa_en  = i_wdata[4:0];
      end else if (off == efr_pkg::OFF_INTL) begin
        n.si = i_wdata[7:6];
      end else if (off == efr_pkg::OFF_EXTRA) begin
        n.xbits = {i_wdata[3], i_wdata[1:0]};
      end
    end

    // register reads, unmapped offsets answer zero
    if (rd) begin
      if (off == efr_pkg::OFF_SA_CTRL) begin
        n.rdata = {q.sa_sel, q.sa_en};
      end else if (off == efr_pkg::OFF_SA_FLAGS) begin
        n.rdata = {3'h0, q.sa_flags};
      end else if (off == efr_pkg::OFF_NIBBLE) begin
        n.rdata = {4'h0, q.nibble}; // RULE2
      end else if (off == efr_pkg::OFF_EV_EN) begin
        n.rdata = q.ev_en;
      end else if (off == efr_pkg::OFF_EV_FLAGS) begin
        n.rdata = q.ev_flags;
      end else if (off == efr_pkg::OFF_TX_CFG) begin
        n.rdata = q.cfg;
      end else if (off == efr_pkg::OFF_INTL) begin
        n.rdata = {q.si, 6'h00};
      end else if (off == efr_pkg::OFF_EXTRA) begin
        n.rdata = {4'h0, q.xbits[2], 1'b0, q.xbits[1:0]};
      end else begin
        n.rdata = 8'h00;
      end
    end

    // a set in the read cycle must survive the clear
    n.ev_flags = (rd_ev ? '0 : q.ev_flags) | set_ev; // RULE4 RULE25
    n.sa_flags = ((rd && (off == efr_pkg::OFF_SA_FLAGS)) ? 5'h00
                  : q.sa_flags) | sa_set;
    n.int_n    = !(|(n.ev_flags & n.ev_en) ||
                   |(n.sa_flags & n.sa_en)); // RULE5 RULE24

    // transmit generator, one timeslot byte per line request
    n.line_valid    = 1'b0;
    n.line_mf_start = 1'b0;
    ebit = q.cfg.far_error_disable
           ? ((q.frame == efr_pkg::FRAME_E1) ? q.si[1] : q.si[0])
           : ((q.frame == efr_pkg::FRAME_E1) ? !i_rx_crc_fail[1]
                                             : !i_rx_crc_fail[0]); // RULE21
    if (q.cfg.gen_fifo_reinit) begin
      n.ts      = '0; // RULE11
      n.frame   = '0;
      n.crc_acc = '0;
      n.crc_tx  = '0;
    end else if (produce) begin
      if (!q.cfg.framing_disable) begin // RULE20
        if (q.ts == efr_pkg::TS_ALIGN) begin
          if (!q.frame[0]) begin
            b[6:0] = efr_pkg::FAS_PATTERN; // RULE20
          end else begin
            b[6] = 1'b1;
          end
          if (q.cfg.crc_mf_generate) begin
            if (!q.frame[0]) begin
              b[7] = q.crc_tx[2'h3 - q.frame[2:1]]; // RULE17 RULE18
            end else if ((q.frame == efr_pkg::FRAME_E1) ||
                         (q.frame == efr_pkg::FRAME_E2)) begin
              b[7] = ebit; // RULE21
            end else begin
              b[7] = efr_pkg::MF_ALIGN[3'h5 - q.frame[3:1]]; // RULE17
            end
          end else if (!q.cfg.intl_bit_disable) begin
            b[7] = q.frame[0] ? q.si[0] : q.si[1]; // RULE16
          end
        end else if ((q.ts == efr_pkg::TS_SIG) && !i_tx_ais) begin // RULE13
          if ({q.cfg.sig_source_hi, q.cfg.sig_source_lo} ==
              efr_pkg::SIG_CAS) begin
            b = i_tx_signalling_stream; // RULE15
            if (q.frame == 4'h0) begin
              b[7:4] = 4'h0; // RULE15
              if (!q.cfg.extra_bit_disable) begin
                b[3]   = q.xbits[2];
                b[1:0] = q.xbits[1:0];
              end else begin
                b[3]   = fifo_data[3];
                b[1:0] = fifo_data[1:0];
              end
            end
          end
          // code 00 and the reserved codes leave the backplane byte
        end
      end
      // C bits count as zero while the remainder is formed
      cb = b;
      if ((q.ts == efr_pkg::TS_ALIGN) && !q.frame[0]) begin
        cb[7] = 1'b0;
      end
      acc             = crc4_byte(q.crc_acc, cb);
      n.line_byte     = b;
      n.line_valid    = 1'b1;
      n.line_mf_start = (q.ts == efr_pkg::TS_ALIGN) && (q.frame == 4'h0);
      if ((q.frame[2:0] == efr_pkg::SUBMF_LAST) &&
          (q.ts == efr_pkg::TS_LAST)) begin
        n.crc_tx  = acc; // RULE18
        n.crc_acc = '0;
      end else begin
        n.crc_acc = acc;
      end
      n.ts = q.ts + 5'h01;
      if (q.ts == efr_pkg::TS_LAST) begin
        n.frame = q.frame + 4'h1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      q       <= '0;
      q.cfg   <= efr_pkg::TX_CFG_RST;
      q.si    <= efr_pkg::INTL_RST;
      q.xbits <= efr_pkg::EXTRA_RST;
      q.int_n <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // ==========================================================
  // checks
  default clocking cb_chk @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);

  sequence s_rd_ev_quiet;
    rd_ev && (set_ev == '0) && !i_rx_frame_start;
  endsequence

  sequence s_frame_start_out;
    produce && !q.cfg.framing_disable && (q.ts == efr_pkg::TS_ALIGN);
  endsequence

  chk_ev_read_clear: assert property ( // RULE4
    s_rd_ev_quiet |=> (q.ev_flags == '0))
    else $error("event flags not cleared by read");

  chk_set_over_clear: assert property ( // RULE25
    (rd_ev && i_rx_frame_start) |=> q.ev_flags.frame_pulse)
    else $error("frame pulse lost in read cycle");

  chk_int_gating: assert property ( // RULE24
    ((q.ev_flags & q.ev_en) == '0) && ((q.sa_flags & q.sa_en) == '0)
    |-> q.int_n)
    else $error("interrupt low with no enabled flag");

  chk_oof_toggle: assert property ( // RULE6
    $changed(i_offset_status) |=> q.ev_flags.offset_change)
    else $error("offset change missed");

  chk_link_toggle: assert property ( // RULE7
    $changed(i_link_id_status) |=> q.ev_flags.link_id_change && !q.int_n
                                || !q.ev_en.link_id_change)
    else $error("link id change missed");

  chk_nibble_hold: assert property ( // RULE3
    (i_rx_submf_start && (q.collect != q.cand)) |=> $stable(q.nibble))
    else $error("nibble updated without debounce");

  chk_alarm_entry: assert property ( // RULE8
    $rose(q.ra_on) |-> q.ev_flags.remote_alarm && $past(q.ra_cnt != '0))
    else $error("remote alarm flag not set on entry");

  chk_fas_insert: assert property ( // RULE20
    (s_frame_start_out and !q.frame[0])
    |=> q.line_valid && (q.line_byte[6:0] == efr_pkg::FAS_PATTERN))
    else $error("alignment pattern missing");

  chk_crc_carry: assert property ( // RULE18
    (s_frame_start_out and (q.frame == 4'h0) and q.cfg.crc_mf_generate)
    |=> q.line_byte[7] == q.crc_tx[3])
    else $error("C1 does not carry previous remainder");

  chk_reinit_hold: assert property ( // RULE11
    q.cfg.gen_fifo_reinit |=> !q.line_valid && (q.ts == 5'h00))
    else $error("generator runs during reinit");

endmodule : efr_framer

// ==== efr_line_model.sv ====
`timescale 1ns/1ps

// ==========================================================
// backplane feeder and line sink
module efr_line_model (
  // design side
  input  wire logic       i_ref_clk,
  input  wire logic       i_tx_ready,
  input  wire logic [7:0] i_line_byte,
  input  wire logic       i_line_valid,
  input  wire logic       i_line_mf_start,
  // stimulus
  output logic      [7:0] o_tx_data,
  output logic            o_tx_valid,
  output logic            o_line_take
);
  initial begin
    o_tx_data   = 8'h00;
    o_tx_valid  = 1'b0;
    o_line_take = 1'b0;
  end

  task automatic push(input logic [7:0] d, output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(negedge i_ref_clk);
      if (i_tx_ready === 1'b1) begin
        o_tx_data  = d;
        o_tx_valid = 1'b1;
        ok         = 1'b1;
      end
    end
    @(negedge i_ref_clk);
    o_tx_valid = 1'b0;
    // released bus must not keep showing the last byte
    o_tx_data  = ~d;
  endtask : push

  task automatic pull(output logic [7:0] b, output logic v,
                      output logic mf);
    @(negedge i_ref_clk);
    o_line_take = 1'b1;
    @(negedge i_ref_clk);
    o_line_take = 1'b0;
    b  = i_line_byte;
    v  = i_line_valid;
    mf = i_line_mf_start;
  endtask : pull
endmodule : efr_line_model

// ==== efr_pkg.sv ====
// Behaviour
// RULE1: eight channels each own this register set, copies spaced 0x80 apart.
// RULE2: read-only nibble holds selected national bit across one sub-multiframe.
// RULE3: nibble updates only after two successive identical sub-multiframe codewords.
// RULE4: reading the event register clears all eight receive event flags.
// RULE5: each event flag drives low interrupt only when enabled; enables reset 0.
// RULE6: offset status change in either direction sets the offset change flag.
// RULE7: link id status change in either direction sets the link change flag.
// RULE8: A bit 1 with E bit 0 held 10 ms sets remote alarm flag.
// RULE9: over 990 zero E bits per second for 5 seconds sets flag.
// RULE10: frame, sub-multiframe, multiframe and signalling multiframe starts set pulse flags.
// RULE11: fifo reinit bit at 1 reinitialises the transmit fifo; resets to 0.
// RULE12: software pulses fifo reinit 1 then 0 after backplane setup.
// RULE13: signalling source bits govern TS16 only while all-ones alarm is 0.
// RULE14: code 00 passes TS16 from data; software sets extra bit disable.
// RULE15: code 11 takes signalling; frame 0 TS16 becomes 0000 X0 Y X1 X2.
// RULE16: without CRC multiframe, international bits use programmed values unless disabled.
// RULE17: with CRC multiframe, international bits carry alignment pattern and CRC-4.
// RULE18: CRC-4 of sub-multiframe n is sent in sub-multiframe n+1.
// RULE19: software enables CRC generation only with framing and intl disable 0.
// RULE20: framing disable 0 inserts FAS; 1 passes data and ignores CRC controls.
// RULE21: with CRC on and far error enabled, frames 13, 15 carry FEBE.
// RULE22: selector 100..111 picks Sa4..Sa7, 000 picks Sa8, others reserved.
// RULE23: a nibble change sets the selected bit's change flag for interrupt.
// RULE24: interrupt is OR of enabled set flags, released once all are read.
// RULE25: flags hold until read; a set in the read cycle wins.
package efr_pkg;

  // ==========================================================
  // timing
  localparam int CLK_HZ       = 40_000_000;
  localparam int RAI_TIME_MS  = 10;
  localparam int RAI_CYCLES   = RAI_TIME_MS * (CLK_HZ / 1000);
  localparam int SEC_TIME_MS  = 1000;
  localparam int SEC_CYCLES   = SEC_TIME_MS * (CLK_HZ / 1000);
  localparam logic [10:0] FEBE_LIMIT   = 11'd990;
  localparam logic [2:0]  FEBE_SECONDS = 3'd5;

  // ==========================================================
  // register map, offsets within one channel
  localparam int          CH_LSB       = 7;
  localparam logic [6:0]  OFF_SA_CTRL  = 7'h3b;
  localparam logic [6:0]  OFF_SA_FLAGS = 7'h3c;
  localparam logic [6:0]  OFF_NIBBLE   = 7'h3d;
  localparam logic [6:0]  OFF_EV_EN    = 7'h3e;
  localparam logic [6:0]  OFF_EV_FLAGS = 7'h3f;
  localparam logic [6:0]  OFF_TX_CFG   = 7'h40;
  localparam logic [6:0]  OFF_INTL     = 7'h42;
  localparam logic [6:0]  OFF_EXTRA    = 7'h43;
  localparam logic [7:0]  TX_CFG_RST   = 8'h60;
  localparam logic [1:0]  INTL_RST     = 2'h3;
  localparam logic [2:0]  EXTRA_RST    = 3'h7;

  // ==========================================================
  // codes and frame layout
  localparam logic [1:0]  SIG_PASS     = 2'h0;
  localparam logic [1:0]  SIG_CAS      = 2'h3;
  localparam logic [2:0]  SEL_SA4      = 3'h4;
  localparam logic [2:0]  SEL_SA5      = 3'h5;
  localparam logic [2:0]  SEL_SA6      = 3'h6;
  localparam logic [2:0]  SEL_SA7      = 3'h7;
  localparam logic [2:0]  SEL_SA8      = 3'h0;
  localparam logic [4:0]  TS_ALIGN     = 5'h00;
  localparam logic [4:0]  TS_SIG       = 5'h10;
  localparam logic [4:0]  TS_LAST      = 5'h1f;
  localparam logic [2:0]  SUBMF_LAST   = 3'h7;
  localparam logic [3:0]  FRAME_E1     = 4'hd;
  localparam logic [3:0]  FRAME_E2     = 4'hf;
  localparam logic [6:0]  FAS_PATTERN  = 7'h1b;
  localparam logic [5:0]  MF_ALIGN     = 6'h0b;
  localparam logic [3:0]  CRC4_POLY    = 4'h3;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic offset_change;
    logic remote_alarm;
    logic continuous_far_error;
    logic link_id_change;
    logic frame_pulse;
    logic crc_submf_pulse;
    logic crc_mf_pulse;
    logic sig_mf_pulse;
  } efr_rx_ev_t;

  typedef struct packed {
    logic gen_fifo_reinit;
    logic sig_source_hi;
    logic sig_source_lo;
    logic crc_mf_generate;
    logic framing_disable;
    logic far_error_disable;
    logic intl_bit_disable;
    logic extra_bit_disable;
  } efr_tx_cfg_t;

  typedef struct packed {
    efr_rx_ev_t  ev_en;
    efr_rx_ev_t  ev_flags;
    efr_tx_cfg_t cfg;
    logic [1:0]  si;
    logic [2:0]  xbits;
    logic [2:0]  sa_sel;
    logic [4:0]  sa_en;
    logic [4:0]  sa_flags;
    logic [3:0]  nibble;
    logic [3:0]  collect;
    logic [3:0]  cand;
    logic        oof_q;
    logic        link_q;
    logic [31:0] ra_cnt;
    logic        ra_on;
    logic [31:0] sec_cnt;
    logic [10:0] febe_cnt;
    logic [2:0]  run;
    logic [4:0]  ts;
    logic [3:0]  frame;
    logic [3:0]  crc_acc;
    logic [3:0]  crc_tx;
    logic [7:0]  rdata;
    logic        int_n;
    logic [7:0]  line_byte;
    logic        line_valid;
    logic        line_mf_start;
  } efr_state_t;

endpackage : efr_pkg
